// [logic/adc_pkg.sv]
// constants and helpers shared by the converter control block
package adc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RESULT_LOW = 8'h78;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h79;
  localparam logic [7:0] IDX_CONTROL_STATUS = 8'h7a;
  localparam logic [7:0] IDX_CONTROL_STATUS_B = 8'h7b;
  localparam logic [7:0] IDX_INPUT_REF_SELECT = 8'h7c;

  // converter_control_status fields
  localparam int CSR_ENABLE = 7;
  localparam int CSR_START = 6;
  localparam int CSR_AUTO_TRIGGER = 5;
  localparam int CSR_DONE_FLAG = 4;
  localparam int CSR_IRQ_ENABLE = 3;
  localparam int CSR_PRESCALE_LSB = 0;

  // input_and_reference_select fields
  localparam int SEL_REFERENCE_LSB = 6;
  localparam int SEL_LEFT_JUSTIFY = 5;
  localparam int SEL_CHANNEL_LSB = 0;

  // converter_control_status_b fields
  localparam int CSRB_TRIGGER_LSB = 0;

  // reset values
  localparam logic [7:0] RST_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] RST_CONTROL_STATUS_B = 8'h00;
  localparam logic [7:0] RST_INPUT_REF_SELECT = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;

  // conversion lengths in converter clock cycles
  localparam logic [4:0] CONV_CYCLES_FIRST = 5'h19;
  localparam logic [4:0] CONV_CYCLES_NORMAL = 5'h0d;

  // reference, channel and trigger codes
  localparam logic [1:0] REF_EXTERNAL_PIN = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_INTERNAL_BANDGAP = 2'h3;
  localparam logic [3:0] CH_LAST_PIN = 4'h7;
  localparam logic [3:0] CH_TEMPERATURE = 4'h8;
  localparam logic [3:0] CH_BANDGAP = 4'he;
  localparam logic [3:0] CH_GROUND = 4'hf;
  localparam logic [2:0] TRIG_FREE_RUNNING = 3'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_BUSY = 1'b1
  } conv_state_e;

  // byte address of a register index on the 12-bit bus
  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'h0, idx, 2'h0};
  endfunction

  // terminal count of the prescaler: divide by 2 for codes 0 and 1
  function automatic logic [6:0] prescale_terminal(input logic [2:0] code);
    logic [7:0] div;
    div = (code < 3'h2) ? 8'h02 : (8'h01 << code);
    prescale_terminal = 7'(div - 8'h01);
  endfunction

endpackage

// [logic/adc_clock_divider.sv]
// system clock divider making the converter clock enable
`timescale 1ns/100ps
module adc_clock_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] prescale_select,
  output logic tick
);

  logic [6:0] count;

  // free count restarts while off so the first tick after enable is a full period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 7'h00;
      tick <= 1'b0;
    end else if (!run) begin
      count <= 7'h00;
      tick <= 1'b0;
    end else if (count >= adc_pkg::prescale_terminal(prescale_select)) begin
      count <= 7'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick <= 1'b0;
    end
  end

endmodule

// [logic/adc_control.sv]
// control, status and result registers of the 10-bit converter
//
// Summary of operation
// - reference field picks pin, supply or bandgap
// - reference/channel writes wait for conversion end
// - justify bit reshapes readable result at once
// - select register bit 4 reads zero
// - channel codes: pins, sensor, bandgap, ground
// - enable on; clearing enable aborts conversion
// - start bit begins conversion; free-run needs one
// - first conversion 25 cycles, others 13
// - start reads one while busy; zero ignored
// - auto-trigger starts on selected trigger edge
// - done flag sets when a conversion ends, even with result frozen
// - flag cleared by vector or writing one
// - request when flag, enable, global enable
// - prescaler divides by 2 up to 128
// - low read freezes result until high read
// - result bit placement per justification, zeros elsewhere
// - trigger source zero is free running
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module adc_control (
  input wire logic clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // system side
  input wire logic [6:0] trigger_events,
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  output logic conversion_done_irq,
  // analog side
  input wire logic [9:0] conversion_result_in,
  output logic converter_powered,
  output logic converter_clock_tick,
  output logic conversion_busy,
  output logic ref_external_pin,
  output logic ref_supply,
  output logic ref_internal_bandgap,
  output logic [7:0] analog_input_select,
  output logic temperature_sensor_input_select,
  output logic bandgap_input_select,
  output logic ground_input_select
);

  // software-visible state
  logic converter_enable;
  logic auto_trigger_enable;
  logic conversion_done_flag;
  logic conversion_done_irq_enable;
  logic [2:0] clock_prescale_select;
  logic [2:0] trigger_source_select;
  logic [1:0] reference_select;
  logic left_justify_result;
  logic [3:0] channel_select;
  logic [9:0] result;
  logic result_locked;

  // conversion engine
  adc_pkg::conv_state_e state;
  logic [4:0] cycles_left;
  logic init_pending;
  logic trigger_prev;

  // bus holding registers
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;

  logic do_write;
  logic wr_csr;
  logic wr_csrb;
  logic wr_sel;
  logic rd_fire;
  logic rd_low;
  logic rd_high;
  logic trigger_now;
  logic trigger_edge;
  logic enable_next;
  logic start_request;
  logic conv_done;
  logic free_run_restart;
  logic begin_conversion;
  logic [7:0] result_low_byte;
  logic [7:0] result_high_byte;

  // true when an address hits the given register index
  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr == adc_pkg::reg_addr(idx));
  endfunction

  // write channel: address and data are taken independently
  assign awready = !aw_held;
  assign wready = !w_held;
  assign do_write = aw_held && w_held && !bvalid;
  // only byte lane 0 carries register data
  assign wr_csr = do_write && w_lane_q && hit(aw_addr_q, adc_pkg::IDX_CONTROL_STATUS);
  assign wr_csrb = do_write && w_lane_q && hit(aw_addr_q, adc_pkg::IDX_CONTROL_STATUS_B);
  assign wr_sel = do_write && w_lane_q && hit(aw_addr_q, adc_pkg::IDX_INPUT_REF_SELECT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_held <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_byte_q <= wdata[7:0];
      w_lane_q <= wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // write response; unmapped addresses answer decode error
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= adc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      if (hit(aw_addr_q, adc_pkg::IDX_CONTROL_STATUS) ||
          hit(aw_addr_q, adc_pkg::IDX_CONTROL_STATUS_B) ||
          hit(aw_addr_q, adc_pkg::IDX_INPUT_REF_SELECT) ||
          hit(aw_addr_q, adc_pkg::IDX_RESULT_LOW) ||
          hit(aw_addr_q, adc_pkg::IDX_RESULT_HIGH)) begin
        bresp <= adc_pkg::RESP_OKAY;
      end else begin
        bresp <= adc_pkg::RESP_DECERR;
      end
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // justified views of the result, recomputed live from the justify bit
  always_comb begin
    if (left_justify_result) begin
      result_high_byte = result[9:2];
      result_low_byte = {result[1:0], 6'h00};
    end else begin
      result_high_byte = {6'h00, result[9:8]};
      result_low_byte = result[7:0];
    end
  end

  // read channel: one read in flight, data registered
  assign arready = !rvalid;
  assign rd_fire = arvalid && arready;
  assign rd_low = rd_fire && hit(araddr, adc_pkg::IDX_RESULT_LOW);
  assign rd_high = rd_fire && hit(araddr, adc_pkg::IDX_RESULT_HIGH);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= adc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rresp <= adc_pkg::RESP_OKAY;
      rdata <= 32'h0000_0000;
      if (rd_low) begin
        rdata[7:0] <= result_low_byte;
      end else if (rd_high) begin
        rdata[7:0] <= result_high_byte;
      end else if (hit(araddr, adc_pkg::IDX_CONTROL_STATUS)) begin
        rdata[7:0] <= {converter_enable, conversion_busy, auto_trigger_enable,
                       conversion_done_flag, conversion_done_irq_enable,
                       clock_prescale_select};
      end else if (hit(araddr, adc_pkg::IDX_CONTROL_STATUS_B)) begin
        rdata[7:0] <= {5'h00, trigger_source_select};
      end else if (hit(araddr, adc_pkg::IDX_INPUT_REF_SELECT)) begin
        rdata[7:0] <= {reference_select, left_justify_result, 1'b0, channel_select};
      end else begin
        rresp <= adc_pkg::RESP_DECERR;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // plain control fields; bit 4 of the select register is never stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      auto_trigger_enable <= adc_pkg::RST_CONTROL_STATUS[adc_pkg::CSR_AUTO_TRIGGER];
      conversion_done_irq_enable <= adc_pkg::RST_CONTROL_STATUS[adc_pkg::CSR_IRQ_ENABLE];
      clock_prescale_select <= adc_pkg::RST_CONTROL_STATUS[adc_pkg::CSR_PRESCALE_LSB +: 3];
      trigger_source_select <= adc_pkg::RST_CONTROL_STATUS_B[adc_pkg::CSRB_TRIGGER_LSB +: 3];
      reference_select <= adc_pkg::RST_INPUT_REF_SELECT[adc_pkg::SEL_REFERENCE_LSB +: 2];
      left_justify_result <= adc_pkg::RST_INPUT_REF_SELECT[adc_pkg::SEL_LEFT_JUSTIFY];
      channel_select <= adc_pkg::RST_INPUT_REF_SELECT[adc_pkg::SEL_CHANNEL_LSB +: 4];
    end else begin
      if (wr_csr) begin
        auto_trigger_enable <= w_byte_q[adc_pkg::CSR_AUTO_TRIGGER];
        conversion_done_irq_enable <= w_byte_q[adc_pkg::CSR_IRQ_ENABLE];
        clock_prescale_select <= w_byte_q[adc_pkg::CSR_PRESCALE_LSB +: 3];
      end
      if (wr_csrb) begin
        trigger_source_select <= w_byte_q[adc_pkg::CSRB_TRIGGER_LSB +: 3];
      end
      if (wr_sel) begin
        reference_select <= w_byte_q[adc_pkg::SEL_REFERENCE_LSB +: 2];
        left_justify_result <= w_byte_q[adc_pkg::SEL_LEFT_JUSTIFY];
        channel_select <= w_byte_q[adc_pkg::SEL_CHANNEL_LSB +: 4];
      end
    end
  end

  // enable bit; the first start after a rising enable needs initialisation
  assign enable_next = wr_csr ? w_byte_q[adc_pkg::CSR_ENABLE] : converter_enable;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      converter_enable <= adc_pkg::RST_CONTROL_STATUS[adc_pkg::CSR_ENABLE];
      init_pending <= 1'b1;
    end else begin
      converter_enable <= enable_next;
      if (!enable_next) begin
        init_pending <= 1'b1;
      end else if (begin_conversion) begin
        init_pending <= 1'b0;
      end
    end
  end

  // selected trigger; free running has no edge source, so selecting it never fires
  always_comb begin
    if (trigger_source_select == adc_pkg::TRIG_FREE_RUNNING) begin
      trigger_now = 1'b0;
    end else begin
      trigger_now = trigger_events[3'(trigger_source_select - 3'h1)];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trigger_prev <= 1'b0;
    end else begin
      trigger_prev <= trigger_now;
    end
  end

  assign trigger_edge = trigger_now && !trigger_prev;

  // start sources: start write, trigger edge, or free-running chain
  assign start_request = (wr_csr && w_byte_q[adc_pkg::CSR_START]) ||
                         (auto_trigger_enable && trigger_edge);
  assign conv_done = (state == adc_pkg::CONV_BUSY) && converter_enable &&
                     converter_clock_tick && (cycles_left == 5'h01);
  assign free_run_restart = conv_done && auto_trigger_enable &&
                            (trigger_source_select == adc_pkg::TRIG_FREE_RUNNING);
  // a request while busy is dropped, not queued
  assign begin_conversion = enable_next && start_request &&
                            (state == adc_pkg::CONV_IDLE);

  // conversion sequencer counting converter clock ticks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= adc_pkg::CONV_IDLE;
      cycles_left <= 5'h00;
    end else begin
      case (state)
        adc_pkg::CONV_IDLE: begin
          if (begin_conversion) begin
            state <= adc_pkg::CONV_BUSY;
            cycles_left <= init_pending ? adc_pkg::CONV_CYCLES_FIRST
                                        : adc_pkg::CONV_CYCLES_NORMAL;
          end
        end
        adc_pkg::CONV_BUSY: begin
          if (!enable_next) begin
            state <= adc_pkg::CONV_IDLE;
            cycles_left <= 5'h00;
          end else if (free_run_restart) begin
            cycles_left <= adc_pkg::CONV_CYCLES_NORMAL;
          end else if (conv_done) begin
            state <= adc_pkg::CONV_IDLE;
            cycles_left <= 5'h00;
          end else if (converter_clock_tick) begin
            cycles_left <= cycles_left - 5'h01;
          end
        end
        default: begin
          state <= adc_pkg::CONV_IDLE;
          cycles_left <= 5'h00;
        end
      endcase
    end
  end

  assign conversion_busy = (state == adc_pkg::CONV_BUSY);
  assign converter_powered = converter_enable;

  // result load; a low-byte read freezes it until the high byte is read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result <= adc_pkg::RST_RESULT;
      result_locked <= 1'b0;
    end else begin
      if (conv_done && !result_locked) begin
        result <= conversion_result_in;
      end
      if (rd_high) begin
        result_locked <= 1'b0;
      end else if (rd_low) begin
        result_locked <= 1'b1;
      end
    end
  end

  // done flag: a completion in the clearing cycle wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conversion_done_flag <= adc_pkg::RST_CONTROL_STATUS[adc_pkg::CSR_DONE_FLAG];
    end else if (conv_done) begin
      conversion_done_flag <= 1'b1;
    end else if (irq_vector_taken || (wr_csr && w_byte_q[adc_pkg::CSR_DONE_FLAG])) begin
      conversion_done_flag <= 1'b0;
    end
  end

  assign conversion_done_irq = conversion_done_flag && conversion_done_irq_enable &&
                               global_irq_enable;

  // reference and channel drives follow the registers only between conversions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_external_pin <= 1'b1;
      ref_supply <= 1'b0;
      ref_internal_bandgap <= 1'b0;
      analog_input_select <= 8'h01;
      temperature_sensor_input_select <= 1'b0;
      bandgap_input_select <= 1'b0;
      ground_input_select <= 1'b0;
    end else if (!conversion_busy || conv_done) begin
      ref_external_pin <= (reference_select == adc_pkg::REF_EXTERNAL_PIN);
      ref_supply <= (reference_select == adc_pkg::REF_SUPPLY);
      ref_internal_bandgap <= (reference_select == adc_pkg::REF_INTERNAL_BANDGAP);
      analog_input_select <= (channel_select <= adc_pkg::CH_LAST_PIN) ?
                             (8'h01 << channel_select[2:0]) : 8'h00;
      temperature_sensor_input_select <= (channel_select == adc_pkg::CH_TEMPERATURE);
      bandgap_input_select <= (channel_select == adc_pkg::CH_BANDGAP);
      ground_input_select <= (channel_select == adc_pkg::CH_GROUND);
    end
  end

  // converter clock runs only while the converter is on
  adc_clock_divider u_divider (
    .clk(clk),
    .rst(rst),
    .run(converter_enable),
    .prescale_select(clock_prescale_select),
    .tick(converter_clock_tick)
  );

endmodule

// [verif/adc_control_props.sv]
// concurrent checks on the converter control block ports
`timescale 1ns/100ps
module adc_control_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic global_irq_enable,
  input wire logic conversion_done_irq,
  input wire logic converter_powered,
  input wire logic converter_clock_tick,
  input wire logic conversion_busy,
  input wire logic ref_external_pin,
  input wire logic ref_supply,
  input wire logic ref_internal_bandgap,
  input wire logic [7:0] analog_input_select,
  input wire logic temperature_sensor_input_select,
  input wire logic bandgap_input_select,
  input wire logic ground_input_select
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // select lines grouped so one check covers each decode
  wire logic [10:0] chan = {analog_input_select, temperature_sensor_input_select,
    bandgap_input_select, ground_input_select};
  wire logic [2:0] refs = {ref_external_pin, ref_supply, ref_internal_bandgap};
  property p_irq_gate;
    !global_irq_enable |-> !conversion_done_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while globally masked");
  property p_busy_power;
    conversion_busy |-> converter_powered;
  endproperty
  a_busy_power: assert property (p_busy_power) else $error("busy while off");
  property p_tick_off;
    !converter_powered && !$past(converter_powered) |-> !converter_clock_tick;
  endproperty
  a_tick_off: assert property (p_tick_off) else $error("tick while off");
  property p_tick_gap;
    converter_clock_tick |=> !converter_clock_tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick faster than half rate");
  property p_ref_hot;
    $onehot0(refs);
  endproperty
  a_ref_hot: assert property (p_ref_hot) else $error("two references selected");
  property p_chan_hot;
    $onehot0(chan);
  endproperty
  a_chan_hot: assert property (p_chan_hot) else $error("two inputs selected");
  // selection may only move at a tick edge, where a conversion ends
  property p_sel_held;
    conversion_busy && $past(conversion_busy) && !$past(converter_clock_tick)
      && !$past(converter_clock_tick, 2) |-> $stable({refs, chan});
  endproperty
  a_sel_held: assert property (p_sel_held) else $error("selection moved mid conversion");
  property p_busy_len;
    $rose(conversion_busy) |=> (conversion_busy || !converter_powered)[*4];
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("conversion ended too soon");
endmodule
bind adc_control adc_control_props u_props (.clk, .rst, .global_irq_enable,
  .conversion_done_irq, .converter_powered, .converter_clock_tick, .conversion_busy,
  .ref_external_pin, .ref_supply, .ref_internal_bandgap, .analog_input_select,
  .temperature_sensor_input_select, .bandgap_input_select, .ground_input_select);

// [verif/adc_analog_model.sv]
// analog core stand-in: the result code follows the selected input
`timescale 1ns/100ps
module adc_analog_model (
  input wire logic [7:0] analog_input_select,
  input wire logic temperature_sensor_input_select,
  input wire logic bandgap_input_select,
  input wire logic ground_input_select,
  output logic [9:0] conversion_result_in
);
  // a distinct code per input, so a wrong mux choice shows in the result
  assign conversion_result_in = temperature_sensor_input_select ? 10'h160 :
    bandgap_input_select ? 10'h2a5 : ground_input_select ? 10'h000 :
    {2'h2, analog_input_select};
endmodule

// [verif/adc_control_bench.sv]
// self-checking bench for the converter control block
`timescale 1ns/100ps
module adc_control_bench;
  localparam logic [11:0] lo_a = 12'h1e0;
  localparam logic [11:0] hi_a = 12'h1e4;
  localparam logic [11:0] ctl_a = 12'h1e8;
  localparam logic [11:0] trg_a = 12'h1ec;
  localparam logic [11:0] sel_a = 12'h1f0;
  logic clk, rst, awvalid, wvalid, arvalid, global_irq_enable, irq_vector_taken;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [6:0] trigger_events;
  logic awready, wready, bvalid, arready, rvalid, conversion_done_irq;
  logic [1:0] bresp, rresp, resp;
  logic [9:0] result;
  logic converter_powered, converter_clock_tick, conversion_busy;
  logic ref_external_pin, ref_supply, ref_internal_bandgap;
  logic [7:0] analog_input_select, rv;
  logic temperature_sensor_input_select, bandgap_input_select, ground_input_select;
  int error_cnt, check_count, n, cyc, dv;
  // response ready lines held high: every answer is taken at once
  adc_control u_dut (.clk, .rst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb(4'h1), .bvalid, .bready(1'b1), .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready(1'b1), .rdata, .rresp, .trigger_events, .global_irq_enable, .irq_vector_taken,
    .conversion_done_irq, .conversion_result_in(result), .converter_powered,
    .converter_clock_tick, .conversion_busy, .ref_external_pin, .ref_supply,
    .ref_internal_bandgap, .analog_input_select, .temperature_sensor_input_select,
    .bandgap_input_select, .ground_input_select);
  adc_analog_model u_analog (.analog_input_select, .temperature_sensor_input_select,
    .bandgap_input_select, .ground_input_select, .conversion_result_in(result));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one clock of any wait; a hung handshake ends the run
  task automatic step();
    @(posedge clk);
    n++;
    if (n > 5000) begin
      $display("MISMATCH timeout expected answer seen none");
      error_cnt++;
      test_done();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ah;
    logic dh;
    ah = 1'b1;
    dh = 1'b1;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      step();
      if (awready) ah = 1'b0;
      if (wready) dh = 1'b0;
      awvalid <= ah;
      wvalid <= dh;
    end while (ah || dh);
    while (!bvalid) step();
    resp = bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do step(); while (!arready);
    arvalid <= 1'b0;
    do step(); while (!rvalid);
    rv = rdata[7:0];
    resp = rresp;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk(nm, rv, e);
  endtask
  task automatic wait_idle();
    n = 0;
    do step(); while (conversion_busy);
  endtask
  // expected reference and input decode for a code used as both fields
  function automatic logic [13:0] exp_dec(input logic [3:0] c);
    logic [13:0] e;
    e = 14'h0;
    case (c[1:0])
      2'h0: e[13] = 1'b1;
      2'h1: e[12] = 1'b1;
      2'h3: e[11] = 1'b1;
      default: e[13] = 1'b0;
    endcase
    if (c < 4'h8) e[3 + int'(c)] = 1'b1;
    if (c == 4'h8) e[2] = 1'b1;
    if (c == 4'he) e[1] = 1'b1;
    if (c == 4'hf) e[0] = 1'b1;
    return e;
  endfunction
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, arvalid, global_irq_enable, irq_vector_taken} = 5'h00;
    {awaddr, araddr, wdata, trigger_events} = '0;
    error_cnt = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values, then an unmapped place in both directions
    chk("pins", analog_input_select, 8'h01);
    rchk("csr", ctl_a, 8'h00);
    rchk("sel", sel_a, 8'h00);
    rchk("trg", trg_a, 8'h00);
    rd(12'h100);
    chk("rd_resp", resp, 2'h3);
    wr(12'h100, 8'hff);
    chk("wr_resp", resp, 2'h3);
    for (int i = 0; i < 16; i++) begin
      wr(sel_a, {i[1:0], 2'b01, i[3:0]});
      rchk("sel", sel_a, {i[1:0], 2'b00, i[3:0]});
      chk("decode", {refs_now(), analog_input_select, temperature_sensor_input_select,
        bandgap_input_select, ground_input_select}, exp_dec(i[3:0]));
    end
    // sensor on the bandgap reference, one single conversion per prescale code
    wr(sel_a, 8'hc8);
    for (int p = 0; p < 8; p++) begin
      dv = (p < 2) ? 2 : (1 << p);
      cyc = ((p == 0) ? 25 : 13) * dv;
      wr(ctl_a, {5'b11000, p[2:0]});
      wait_idle();
      chk("conv_len", (n >= cyc - dv - 4) && (n <= cyc + 4), 1'b1);
      rchk("csr_done", ctl_a, {5'b10010, p[2:0]});
      rchk("res_lo", lo_a, 8'h60);
      rchk("res_hi", hi_a, 8'h01);
      wr(ctl_a, {5'b10000, p[2:0]});
      rchk("flag_kept", ctl_a, {5'b10010, p[2:0]});
      wr(ctl_a, {5'b10010, p[2:0]});
      rchk("flag_clr", ctl_a, {5'b10000, p[2:0]});
    end
    wr(sel_a, 8'he8);
    rchk("left_lo", lo_a, 8'h00);
    rchk("left_hi", hi_a, 8'h58);
    // software math: code 0x160, signed offset -3, unity gain gives one degree
    chk("celsius", 16'((int'(rv) * 4 - 373 + int'(8'shfd)) * 128 / int'(8'h80) + 25),
      16'h0001);
    wr(sel_a, 8'hc8);
    // completion request: masked, raised, then withdrawn by the vector
    wr(ctl_a, 8'hc9);
    wait_idle();
    chk("irq_masked", conversion_done_irq, 1'b0);
    global_irq_enable <= 1'b1;
    @(posedge clk);
    chk("irq", conversion_done_irq, 1'b1);
    irq_vector_taken <= 1'b1;
    @(posedge clk);
    irq_vector_taken <= 1'b0;
    @(posedge clk);
    chk("irq_taken", conversion_done_irq, 1'b0);
    rchk("csr_vec", ctl_a, 8'h89);
    // channel change during a conversion waits for its end
    wr(ctl_a, 8'hc3);
    rchk("start_rd", ctl_a, 8'hc3);
    wr(sel_a, 8'hcf);
    // one more edge, so an ungated decode would already show the new channel
    @(posedge clk);
    chk("held_ch", temperature_sensor_input_select, 1'b1);
    wait_idle();
    @(posedge clk);
    chk("new_ch", ground_input_select, 1'b1);
    rchk("res_lo", lo_a, 8'h60);
    rchk("res_hi", hi_a, 8'h01);
    wr(ctl_a, 8'hd3);
    wr(ctl_a, 8'h03);
    chk("abort", conversion_busy, 1'b0);
    chk("power_off", converter_powered, 1'b0);
    rchk("csr_off", ctl_a, 8'h03);
    // a low-byte read freezes the result until the high byte is read
    rd(lo_a);
    wr(ctl_a, 8'hc3);
    wait_idle();
    rchk("locked_hi", hi_a, 8'h01);
    wr(ctl_a, 8'hd3);
    wait_idle();
    rchk("new_lo", lo_a, 8'h00);
    rchk("new_hi", hi_a, 8'h00);
    // auto trigger on event 1; a second edge while busy is dropped
    wr(trg_a, 8'h02);
    wr(ctl_a, 8'hb3);
    chk("no_trig", conversion_busy, 1'b0);
    trigger_events <= 7'h02;
    n = 0;
    do step(); while (!conversion_busy);
    trigger_events <= 7'h00;
    @(posedge clk);
    trigger_events <= 7'h02;
    wait_idle();
    repeat (4) @(posedge clk);
    chk("one_conv", conversion_busy, 1'b0);
    rchk("csr_auto", ctl_a, 8'hb3);
    // each source code follows its own event flag and ignores the others
    for (int s = 1; s < 8; s++) begin
      wr(trg_a, {5'h00, s[2:0]});
      trigger_events <= ~7'(1 << (s - 1));
      repeat (2) @(posedge clk);
      chk("src_other", conversion_busy, 1'b0);
      trigger_events <= 7'h7f;
      n = 0;
      do step(); while (!conversion_busy);
      trigger_events <= 7'h00;
      wait_idle();
    end
    trigger_events <= 7'h00;
    wr(trg_a, 8'h00);
    // a false trigger from the switch would show busy only after these edges
    repeat (2) @(posedge clk);
    chk("no_trig_free", conversion_busy, 1'b0);
    wr(ctl_a, 8'hfb);
    n = 0;
    do step(); while (!conversion_done_irq);
    chk("free_run", conversion_busy, 1'b1);
    wr(ctl_a, 8'h10);
    chk("stop", conversion_busy, 1'b0);
    test_done();
  end
  function automatic logic [2:0] refs_now();
    return {ref_external_pin, ref_supply, ref_internal_bandgap};
  endfunction
endmodule
